/* File: shared/ipv_pkg.sv */
// Package: register map, field layout, reset values and timing of the interrupt priority block
package ipv_pkg;
    localparam int NUM_SRC   = 11;
    localparam int NUM_TRAP  = 4;
    localparam int STACK_DEP = 4;

    // Register indices on the register port
    localparam logic [3:0] REG_DMA3_PRIO    = 4'h0;
    localparam logic [3:0] REG_DMA4_PP_PRIO = 4'h1;
    localparam logic [3:0] REG_RTC_D5_PRIO  = 4'h2;
    localparam logic [3:0] REG_CRC_UE_PRIO  = 4'h3;
    localparam logic [3:0] REG_CAN_D67_PRIO = 4'h4;
    localparam logic [3:0] REG_VEC_STATUS   = 4'h5;
    localparam logic [3:0] REG_PEND_FLAGS   = 4'h6;
    localparam logic [3:0] REG_SRC_ENABLE   = 4'h7;
    localparam logic [3:0] REG_INT_CTRL1    = 4'h8;

    // Source numbering
    localparam int SRC_DMA3 = 0;
    localparam int SRC_DMA4 = 1;
    localparam int SRC_PMP  = 2;
    localparam int SRC_RTC  = 3;
    localparam int SRC_DMA5 = 4;
    localparam int SRC_CRC  = 5;
    localparam int SRC_U2E  = 6;
    localparam int SRC_U1E  = 7;
    localparam int SRC_CAN  = 8;
    localparam int SRC_DMA7 = 9;
    localparam int SRC_DMA6 = 10;

    // Field positions
    localparam logic [3:0] LSB_0  = 4'h0;
    localparam logic [3:0] LSB_4  = 4'h4;
    localparam logic [3:0] LSB_8  = 4'h8;
    localparam logic [3:0] LSB_12 = 4'hc;

    // Per source: register holding its field, and the field's low bit ([10] down to [0])
    localparam logic [NUM_SRC-1:0][3:0] SRC_REG = {
        REG_CAN_D67_PRIO, REG_CAN_D67_PRIO, REG_CAN_D67_PRIO,
        REG_CRC_UE_PRIO, REG_CRC_UE_PRIO, REG_CRC_UE_PRIO,
        REG_RTC_D5_PRIO, REG_RTC_D5_PRIO,
        REG_DMA4_PP_PRIO, REG_DMA4_PP_PRIO, REG_DMA3_PRIO};
    localparam logic [NUM_SRC-1:0][3:0] SRC_LSB = {
        LSB_0, LSB_4, LSB_8, LSB_4, LSB_8, LSB_12, LSB_4, LSB_8, LSB_4, LSB_8, LSB_0};

    localparam int LEVEL_LSB     = 8;
    localparam int NEST_DIS_BIT  = 15;
    localparam int TRAP_FLAG_LSB = 0;

    localparam logic [2:0] PRIO_RESET  = 3'h4;
    localparam logic [2:0] PRIO_OFF    = 3'h0;
    localparam logic [3:0] LEVEL_USER_MAX = 4'h7;
    localparam logic [3:0] LEVEL_TIMED_DISABLE_INSTR_MAX = 4'h6;
    localparam logic [3:0] LEVEL_TRAP_TOP = 4'hf;
    localparam logic [6:0] VEC_TRAP_BASE  = 7'h00;
    localparam logic [6:0] VEC_SRC_BASE   = 7'h04;

    // Cycles the core ignores a request after taking one, while the new level propagates
    localparam logic [1:0] TAKE_HOLDOFF = 2'h2;
endpackage

/* File: shared/ipv_link_if.sv */
// Interface joining the interrupt controller and the processor core end
`timescale 1ns/1ns
`default_nettype none
interface ipv_link_if;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  reg_idx;
    logic [15:0] reg_wdata;
    logic [15:0] reg_rdata;
    logic        reg_rvalid;
    logic        irq_req;
    logic [3:0]  irq_level;
    logic [6:0]  irq_vec;
    logic        irq_ack;
    logic [3:0]  cpu_level;
    logic        timed_disable_instr_active;
    logic        in_handler;

    modport ctl (input reg_wr, reg_rd, reg_idx, reg_wdata, irq_ack, cpu_level, timed_disable_instr_active, in_handler,
                 output reg_rdata, reg_rvalid, irq_req, irq_level, irq_vec);
    modport cpu (output reg_wr, reg_rd, reg_idx, reg_wdata, irq_ack, cpu_level, timed_disable_instr_active, in_handler,
                 input reg_rdata, reg_rvalid, irq_req, irq_level, irq_vec);
endinterface
`default_nettype wire

/* File: src/ipv_ctl.sv */
// Interrupt controller end: priority registers, flags, masking, arbitration and vector status
`timescale 1ns/1ns
`default_nettype none
module ipv_ctl #(
    parameter bit HAS_CAN = 1'b1
) (
    input  wire logic                          clk_sys,
    input  wire logic                          sys_rst,
    ipv_link_if.ctl                            link,
    input  wire logic [ipv_pkg::NUM_SRC-1:0]   src_event,
    input  wire logic [ipv_pkg::NUM_TRAP-1:0]  trap_event,
    output logic      [ipv_pkg::NUM_SRC-1:0]   pend_flags,
    output logic      [ipv_pkg::NUM_TRAP-1:0]  trap_flags
);
    import ipv_pkg::*;

    typedef struct packed {
        logic [NUM_SRC-1:0][2:0] prio;
        logic [NUM_SRC-1:0]      flag;
        logic [NUM_SRC-1:0]      en;
        logic                    nest_dis;
        logic [NUM_TRAP-1:0]     trap;
        logic [3:0]              lvl;
        logic [6:0]              vec;
        logic                    req;
        logic [15:0]             rdata;
        logic                    rvalid;
    } ipv_ctl_state_t;

    ipv_ctl_state_t s_q;
    ipv_ctl_state_t s_d;

    logic [NUM_SRC-1:0]  clr_src;
    logic [NUM_TRAP-1:0] clr_trap;
    logic [3:0]          best_lvl;
    logic [6:0]          best_vec;
    logic                best_any;
    logic [3:0]          cand_lvl;
    logic [15:0]         rword;
    logic [NUM_SRC-1:0]  src_ok;
    logic [NUM_SRC-1:0]  prio_hit;
    logic [NUM_SRC-1:0][15:0] field_rd;

    // Per-source decode and masking, one copy per source; the arbiter only ranks what passes
    for (genvar g = 0; g < NUM_SRC; g++) begin : g_src
        logic [3:0] lvl_g;
        logic       ok_g;

        assign prio_hit[g] = link.reg_idx == SRC_REG[g];
        assign field_rd[g] = prio_hit[g] ? (16'(s_q.prio[g]) << SRC_LSB[g]) : 16'h0000;

        always_comb begin
            lvl_g = {1'b0, s_q.prio[g]};
            ok_g  = s_q.flag[g] && s_q.en[g] && (s_q.prio[g] != PRIO_OFF);
            if (g == SRC_CAN && !HAS_CAN) begin
                // Field stays writable so software written for both variants runs unchanged
                ok_g = 1'b0;
            end
            if (link.timed_disable_instr_active && lvl_g <= LEVEL_TIMED_DISABLE_INSTR_MAX) begin
                // Level 7 stays live so a critical source is never held off by a timed disable
                ok_g = 1'b0;
            end
            if (s_q.nest_dis && link.in_handler) begin
                ok_g = 1'b0;
            end
            if (lvl_g <= link.cpu_level) begin
                ok_g = 1'b0;
            end
        end

        assign src_ok[g] = ok_g;
    end

    always_comb begin
        s_d      = s_q;
        clr_src  = '0;
        clr_trap = '0;
        best_lvl = '0;
        best_vec = '0;
        best_any = 1'b0;
        cand_lvl = '0;
        rword    = '0;

        // Register writes; only field bits are stored, the rest is dropped
        if (link.reg_wr) begin
            for (int i = 0; i < NUM_SRC; i++) begin
                if (prio_hit[i]) begin
                    s_d.prio[i] = link.reg_wdata[SRC_LSB[i] +: 3];
                end
            end
            if (link.reg_idx == REG_PEND_FLAGS) begin
                clr_src = link.reg_wdata[NUM_SRC-1:0];
            end
            if (link.reg_idx == REG_SRC_ENABLE) begin
                s_d.en = link.reg_wdata[NUM_SRC-1:0];
            end
            if (link.reg_idx == REG_INT_CTRL1) begin
                s_d.nest_dis = link.reg_wdata[NEST_DIS_BIT];
                clr_trap     = link.reg_wdata[TRAP_FLAG_LSB +: NUM_TRAP];
            end
        end
        // Write-one-to-clear; an event in the clearing cycle still sets the flag
        s_d.flag = (s_q.flag & ~clr_src) | src_event;
        s_d.trap = (s_q.trap & ~clr_trap) | trap_event;

        // Arbitration: scan from the highest vector down so equal levels settle on the lower vector
        for (int i = NUM_SRC - 1; i >= 0; i--) begin
            cand_lvl = {1'b0, s_q.prio[i]};
            if (src_ok[i] && cand_lvl >= best_lvl) begin
                best_any = 1'b1;
                best_lvl = cand_lvl;
                best_vec = VEC_SRC_BASE + 7'(i);
            end
        end
        // Traps: only a trap of equal or higher level already in service holds one back
        for (int t = NUM_TRAP - 1; t >= 0; t--) begin
            cand_lvl = LEVEL_TRAP_TOP - 4'(t);
            if (s_q.trap[t] && cand_lvl > link.cpu_level && cand_lvl >= best_lvl) begin
                best_any = 1'b1;
                best_lvl = cand_lvl;
                best_vec = VEC_TRAP_BASE + 7'(t);
            end
        end
        s_d.req = best_any;
        s_d.lvl = best_lvl;
        s_d.vec = best_vec;

        // Register reads, answered one cycle later
        // Each source contributes only its own field, so every other bit reads zero
        for (int i = 0; i < NUM_SRC; i++) begin
            rword = rword | field_rd[i];
        end
        case (link.reg_idx)
            REG_VEC_STATUS: begin
                rword[LEVEL_LSB +: 4] = s_q.lvl;
                rword[6:0]            = s_q.vec;
            end
            REG_PEND_FLAGS: rword[NUM_SRC-1:0] = s_q.flag;
            REG_SRC_ENABLE: rword[NUM_SRC-1:0] = s_q.en;
            REG_INT_CTRL1: begin
                rword[NEST_DIS_BIT]                  = s_q.nest_dis;
                rword[TRAP_FLAG_LSB +: NUM_TRAP]     = s_q.trap;
            end
            default: ;
        endcase
        s_d.rvalid = link.reg_rd;
        s_d.rdata  = link.reg_rd ? rword : 16'h0000;
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q          <= '0;
            s_q.prio     <= {NUM_SRC{PRIO_RESET}};
        end else begin
            s_q <= s_d;
        end
    end

    assign link.reg_rdata  = s_q.rdata;
    assign link.reg_rvalid = s_q.rvalid;
    assign link.irq_req    = s_q.req;
    assign link.irq_level  = s_q.lvl;
    assign link.irq_vec    = s_q.vec;
    assign pend_flags      = s_q.flag;
    assign trap_flags      = s_q.trap;
endmodule
`default_nettype wire

/* File: src/ipv_cpu.sv */
// Processor core end: takes requests, keeps the level stack, timed disable and register access
`timescale 1ns/1ns
`default_nettype none
module ipv_cpu (
    input  wire logic        clk_sys,
    input  wire logic        sys_rst,
    ipv_link_if.cpu          link,
    input  wire logic        usr_reg_wr,
    input  wire logic        usr_reg_rd,
    input  wire logic [3:0]  usr_reg_idx,
    input  wire logic [15:0] usr_reg_wdata,
    output logic      [15:0] usr_rdata,
    output logic             usr_rvalid,
    input  wire logic [15:0] usr_pc,
    input  wire logic [7:0]  usr_srl,
    input  wire logic        usr_set_level,
    input  wire logic [2:0]  usr_level_val,
    input  wire logic        usr_timed_disable_instr,
    input  wire logic [13:0] usr_timed_disable_instr_cycles,
    input  wire logic        usr_return_from_interrupt_instr,
    output logic             taken,
    output logic      [6:0]  taken_vec,
    output logic      [3:0]  cpu_level,
    output logic             restored,
    output logic      [15:0] restored_pc,
    output logic      [7:0]  restored_srl
);
    import ipv_pkg::*;

    typedef struct packed {
        logic [STACK_DEP-1:0][27:0] stack;
        logic [2:0]                 depth;
        logic [3:0]                 level;
        logic [13:0]                timed_disable_instr_cnt;
        logic [1:0]                 holdoff;
        logic                       ack;
        logic                       rd;
        logic                       wr;
        logic [3:0]                 idx;
        logic [15:0]                wdata;
        logic [15:0]                rdata;
        logic                       rvalid;
        logic [6:0]                 vec;
        logic                       restored;
        logic [15:0]                rpc;
        logic [7:0]                 rsrl;
    } ipv_cpu_state_t;

    ipv_cpu_state_t s_q;
    ipv_cpu_state_t s_d;
    logic [27:0]    top;

    always_comb begin
        s_d          = s_q;
        top          = '0;
        s_d.ack      = 1'b0;
        s_d.restored = 1'b0;
        s_d.wr       = usr_reg_wr;
        s_d.rd       = usr_reg_rd;
        s_d.idx      = usr_reg_idx;
        s_d.wdata    = usr_reg_wdata;
        s_d.rvalid   = link.reg_rvalid;
        if (link.reg_rvalid) begin
            s_d.rdata = link.reg_rdata;
        end
        if (s_q.holdoff != 2'h0) begin
            s_d.holdoff = s_q.holdoff - 2'h1;
        end
        if (s_q.timed_disable_instr_cnt != 14'h0000) begin
            s_d.timed_disable_instr_cnt = s_q.timed_disable_instr_cnt - 14'h0001;
        end
        if (usr_timed_disable_instr) begin
            s_d.timed_disable_instr_cnt = usr_timed_disable_instr_cycles;
        end
        // Software may only move the level within the user range
        if (usr_set_level) begin
            s_d.level = {1'b0, usr_level_val};
        end
        if (usr_return_from_interrupt_instr && s_q.depth != 3'h0) begin
            top          = s_q.stack[s_q.depth - 3'h1];
            s_d.rpc      = top[27:12];
            s_d.rsrl     = top[11:4];
            s_d.level    = top[3:0];
            s_d.depth    = s_q.depth - 3'h1;
            s_d.restored = 1'b1;
        end else if (link.irq_req && s_q.holdoff == 2'h0 && s_q.depth != 3'(STACK_DEP)
                     && link.irq_level > s_q.level) begin
            // Full stack stalls new takes rather than losing a return frame
            s_d.stack[s_q.depth[1:0]] = {usr_pc, usr_srl, s_q.level};
            s_d.depth   = s_q.depth + 3'h1;
            s_d.level   = link.irq_level;
            s_d.vec     = link.irq_vec;
            s_d.ack     = 1'b1;
            s_d.holdoff = TAKE_HOLDOFF;
        end
    end

    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign link.reg_wr      = s_q.wr;
    assign link.reg_rd      = s_q.rd;
    assign link.reg_idx     = s_q.idx;
    assign link.reg_wdata   = s_q.wdata;
    assign link.irq_ack     = s_q.ack;
    assign link.cpu_level   = s_q.level;
    assign link.timed_disable_instr_active = s_q.timed_disable_instr_cnt != 14'h0000;
    assign link.in_handler  = s_q.depth != 3'h0;
    assign usr_rdata        = s_q.rdata;
    assign usr_rvalid       = s_q.rvalid;
    assign taken            = s_q.ack;
    assign taken_vec        = s_q.vec;
    assign cpu_level        = s_q.level;
    assign restored         = s_q.restored;
    assign restored_pc      = s_q.rpc;
    assign restored_srl     = s_q.rsrl;
endmodule
`default_nettype wire

/* File: test/ipv_checker.sv */
// Checker: link timing, masking and register read rules of the interrupt controller
`timescale 1ns/1ns
`default_nettype none
module ipv_checker (
    input wire logic        clk_sys,
    input wire logic        sys_rst,
    input wire logic        reg_rd,
    input wire logic [3:0]  reg_idx,
    input wire logic [15:0] reg_rdata,
    input wire logic        reg_rvalid,
    input wire logic        irq_req,
    input wire logic [3:0]  irq_level,
    input wire logic [6:0]  irq_vec,
    input wire logic        irq_ack,
    input wire logic [3:0]  cpu_level,
    input wire logic        timed_disable_instr_active
);
    // Implemented bits per register index, status last
    localparam logic [15:0] IMPL [6] = '{16'h0007, 16'h0770, 16'h0770, 16'h7770, 16'h0777, 16'h0f7f};
    logic [3:0] idx_q;
    // Read data lands one cycle after the request, so the index is kept for that cycle
    always_ff @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            idx_q <= 4'h0;
        end else begin
            idx_q <= reg_idx;
        end
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_ack_cause; irq_ack |-> $past(irq_req) && $past(irq_level) > $past(cpu_level); endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("take without a higher request");
    property p_level_load; irq_ack |-> cpu_level == $past(irq_level); endproperty
    a_level_load: assert property (p_level_load) else $error("level not loaded on take");
    property p_above; irq_req |-> irq_level > $past(cpu_level); endproperty
    a_above: assert property (p_above) else $error("request not above cpu level");
    property p_timed_disable_instr; irq_req && $past(timed_disable_instr_active) |-> irq_level > 4'h6; endproperty
    a_timed_disable_instr: assert property (p_timed_disable_instr) else $error("low level request during timed disable");
    property p_trap_vec; irq_req && irq_level > 4'h7 |-> irq_vec == {3'h0, 4'hf - irq_level}; endproperty
    a_trap_vec: assert property (p_trap_vec) else $error("trap vector and level disagree");
    property p_user_vec; irq_req && irq_level < 4'h8 |-> irq_level != 4'h0 && irq_vec >= 7'h04 && irq_vec < 7'h0f;
    endproperty
    a_user_vec: assert property (p_user_vec) else $error("bad user request");
    property p_rd_ans; reg_rd |=> reg_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read not answered");
    property p_rsv; reg_rvalid && idx_q < 4'h6 |-> (reg_rdata & ~IMPL[idx_q]) == 16'h0000; endproperty
    a_rsv: assert property (p_rsv) else $error("unimplemented bits not zero");
    c_trap: cover property (irq_ack && cpu_level > 4'h7);
    c_disi7: cover property (irq_ack && timed_disable_instr_active && cpu_level == 4'h7);
    c_status: cover property (reg_rvalid && idx_q == 4'h5);
endmodule
`default_nettype wire

/* File: test/ipv_tb.sv */
// Testbench: both ends joined on the link; register, take, return and masking scenarios
`timescale 1ns/1ns
`default_nettype none
module ipv_tb;
    import ipv_pkg::*;
    localparam logic [31:0] NONE = 32'hdead_beef;
    localparam logic [15:0] MSK [5] = '{16'h0007, 16'h0770, 16'h0770, 16'h7770, 16'h0777};
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic        usr_reg_wr = 1'b0;
    logic        usr_reg_rd = 1'b0;
    logic [3:0]  usr_reg_idx = 4'h0;
    logic [15:0] usr_reg_wdata = 16'h0000;
    logic [15:0] usr_pc = 16'h0000;
    logic [7:0]  usr_srl = 8'h00;
    logic        usr_set_level = 1'b0;
    logic [2:0]  usr_level_val = 3'h0;
    logic        usr_timed_disable_instr = 1'b0;
    logic [13:0] usr_timed_disable_instr_cycles = 14'h0000;
    logic        usr_return_from_interrupt_instr = 1'b0;
    logic [10:0] src_event = 11'h000;
    logic [3:0]  trap_event = 4'h0;
    logic [15:0] usr_rdata, restored_pc;
    logic [7:0]  restored_srl;
    logic [6:0]  taken_vec;
    logic [3:0]  cpu_level;
    logic        usr_rvalid, taken, restored;
    logic [10:0] pend_flags;
    logic [3:0]  trap_flags;
    int          err_total = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [31:0] rd_q[$], tk_q[$], rs_q[$];
    ipv_link_if link ();
    ipv_ctl #(.HAS_CAN(1'b0)) ipv_ctl_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .src_event(src_event),
        .trap_event(trap_event), .pend_flags(pend_flags), .trap_flags(trap_flags));
    ipv_cpu ipv_cpu_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .usr_reg_wr(usr_reg_wr),
        .usr_reg_rd(usr_reg_rd), .usr_reg_idx(usr_reg_idx), .usr_reg_wdata(usr_reg_wdata), .usr_rdata(usr_rdata),
        .usr_rvalid(usr_rvalid), .usr_pc(usr_pc), .usr_srl(usr_srl), .usr_set_level(usr_set_level),
        .usr_level_val(usr_level_val), .usr_timed_disable_instr(usr_timed_disable_instr), .usr_timed_disable_instr_cycles(usr_timed_disable_instr_cycles),
        .usr_return_from_interrupt_instr(usr_return_from_interrupt_instr), .taken(taken), .taken_vec(taken_vec), .cpu_level(cpu_level),
        .restored(restored), .restored_pc(restored_pc), .restored_srl(restored_srl));
    ipv_checker ipv_checker_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_rd(link.reg_rd), .reg_idx(link.reg_idx),
        .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid), .irq_req(link.irq_req),
        .irq_level(link.irq_level), .irq_vec(link.irq_vec), .irq_ack(link.irq_ack),
        .cpu_level(link.cpu_level), .timed_disable_instr_active(link.timed_disable_instr_active));
    initial begin
        forever #5 clk_sys = ~clk_sys;
    end
    task automatic cmp(logic [31:0] g, logic [31:0] e);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_rd();
        cmp({16'h0000, usr_rdata}, rd_q.size() > 0 ? rd_q.pop_front() : NONE);
    endtask
    task automatic cmp_tk();
        cmp({21'h0, cpu_level, taken_vec}, tk_q.size() > 0 ? tk_q.pop_front() : NONE);
    endtask
    task automatic cmp_rs();
        cmp({4'h0, cpu_level, restored_pc, restored_srl}, rs_q.size() > 0 ? rs_q.pop_front() : NONE);
    endtask
    task automatic cmp_flag(logic [31:0] g, logic [31:0] e);
        cmp(g, e);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Results are matched in arrival order; anything unexpected meets the sentinel
    always @(negedge clk_sys) begin
        if (usr_rvalid === 1'b1) begin
            cmp_rd();
        end
        if (taken === 1'b1) begin
            cmp_tk();
        end
        if (restored === 1'b1) begin
            cmp_rs();
        end
    end
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            give_verdict();
        end
    end
    task automatic tick(int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task automatic wr(logic [3:0] i, logic [15:0] d);
        @(posedge clk_sys);
        usr_reg_wr <= 1'b1;
        usr_reg_idx <= i;
        usr_reg_wdata <= d;
        @(posedge clk_sys);
        usr_reg_wr <= 1'b0;
    endtask
    task automatic rd(logic [3:0] i, logic [15:0] e);
        rd_q.push_back({16'h0000, e});
        @(posedge clk_sys);
        usr_reg_rd <= 1'b1;
        usr_reg_idx <= i;
        @(posedge clk_sys);
        usr_reg_rd <= 1'b0;
    endtask
    // Kinds: 0 source mask, 1 trap mask, 2 return, 3 set level, 4 timed disable
    task automatic act(int k, int v);
        @(posedge clk_sys);
        case (k)
            0: src_event <= 11'(v);
            1: trap_event <= 4'(v);
            2: usr_return_from_interrupt_instr <= 1'b1;
            3: usr_set_level <= 1'b1;
            default: usr_timed_disable_instr <= 1'b1;
        endcase
        usr_level_val <= 3'(v);
        usr_timed_disable_instr_cycles <= 14'(v);
        @(posedge clk_sys);
        src_event <= 11'h000;
        trap_event <= 4'h0;
        usr_return_from_interrupt_instr <= 1'b0;
        usr_set_level <= 1'b0;
        usr_timed_disable_instr <= 1'b0;
    endtask
    task automatic tk(int l, int s, bit t);
        tk_q.push_back({21'h0, 4'(l), t ? 7'(s) : VEC_SRC_BASE + 7'(s)});
    endtask
    task automatic ret(logic [15:0] pc, int l);
        rs_q.push_back({4'h0, 4'(l), pc, usr_srl});
        act(2, 0);
        tick(6);
    endtask
    initial begin
        logic [15:0] w;
        logic [15:0] p1;
        void'($urandom(32'h9059760f));
        repeat (4) @(posedge clk_sys);
        sys_rst <= 1'b0;
        usr_pc <= 16'($urandom());
        usr_srl <= 8'($urandom());
        rd(REG_DMA3_PRIO, 16'h0004);
        rd(REG_DMA4_PP_PRIO, 16'h0440);
        rd(REG_RTC_D5_PRIO, 16'h0440);
        rd(REG_CRC_UE_PRIO, 16'h4440);
        rd(REG_CAN_D67_PRIO, 16'h0444);
        rd(4'hf, 16'h0000);
        $display("test reset done");
        for (int i = 0; i < 5; i++) begin
            w = 16'($urandom());
            wr(4'(i), w);
            rd(4'(i), w & MSK[i]);
        end
        $display("test fields done");
        wr(REG_SRC_ENABLE, 16'h07ff);
        wr(REG_DMA3_PRIO, 16'h0005);
        tk(5, SRC_DMA3, 0);
        act(0, 32'h0001);
        tick(6);
        cmp_flag({21'h0, pend_flags}, 32'h0000_0001);
        // The flag is still set, so the take after the return is queued first
        tk(5, SRC_DMA3, 0);
        ret(usr_pc, 0);
        wr(REG_PEND_FLAGS, 16'h0001);
        ret(usr_pc, 0);
        wr(REG_DMA4_PP_PRIO, 16'h0660);
        tk(6, SRC_DMA4, 0);
        tk(6, SRC_PMP, 0);
        act(0, 32'h0006);
        tick(6);
        wr(REG_PEND_FLAGS, 16'h0002);
        ret(usr_pc, 0);
        wr(REG_PEND_FLAGS, 16'h0004);
        ret(usr_pc, 0);
        $display("test take done");
        wr(REG_SRC_ENABLE, 16'h03ff);
        wr(REG_DMA3_PRIO, 16'h0000);
        wr(REG_CAN_D67_PRIO, 16'h0777);
        act(0, 32'h0501);
        tick(8);
        wr(REG_PEND_FLAGS, 16'h0501);
        act(3, 7);
        wr(REG_RTC_D5_PRIO, 16'h0700);
        act(0, 32'h0008);
        tick(8);
        tk(7, SRC_RTC, 0);
        act(3, 0);
        tick(6);
        wr(REG_PEND_FLAGS, 16'h0008);
        ret(usr_pc, 0);
        $display("test mask done");
        wr(REG_RTC_D5_PRIO, 16'h0600);
        wr(REG_CAN_D67_PRIO, 16'h0070);
        act(4, 60);
        act(0, 32'h0008);
        tk(7, SRC_DMA7, 0);
        act(0, 32'h0200);
        tick(6);
        wr(REG_PEND_FLAGS, 16'h0200);
        ret(usr_pc, 0);
        tk(6, SRC_RTC, 0);
        tick(60);
        wr(REG_PEND_FLAGS, 16'h0008);
        ret(usr_pc, 0);
        act(3, 7);
        act(4, 60);
        tk(14, 1, 1);
        act(1, 32'h0002);
        tick(6);
        cmp_flag({28'h0, trap_flags}, 32'h0000_0002);
        tk(14, 1, 1);
        ret(usr_pc, 7);
        wr(REG_INT_CTRL1, 16'h0002);
        ret(usr_pc, 7);
        act(3, 0);
        tick(60);
        $display("test trap done");
        // Nesting off: the second source must wait, so its saved pc differs
        wr(REG_INT_CTRL1, 16'h8000);
        wr(REG_RTC_D5_PRIO, 16'h0360);
        tk(3, SRC_RTC, 0);
        act(0, 32'h0008);
        tick(6);
        p1 = usr_pc;
        usr_pc <= ~p1;
        act(0, 32'h0010);
        tick(8);
        wr(REG_PEND_FLAGS, 16'h0008);
        tk(6, SRC_DMA5, 0);
        ret(p1, 0);
        wr(REG_PEND_FLAGS, 16'h0010);
        ret(~p1, 0);
        $display("test nesting done");
        err_total += rd_q.size() + tk_q.size() + rs_q.size();
        give_verdict();
    end
endmodule
`default_nettype wire
